//--- include/arls_pkg.sv
// Constants, field layout and state type for the restart / list swap block.
// Assumes an 8-bit register data bus and a single 125 MHz bus clock.
//
// Functional notes
// RL1 - Restart set and idle: fetch top command
// RL2 - Clear restart once first command loaded
// RL3 - Bits set only while converter enabled
// RL4 - Writing zero leaves restart, load-ok unchanged
// RL5 - Writing one to set restart flags overrun
// RL6 - Access field picks bus or internal interface
// RL7 - Internal restart sets bit; repeat is overrun
// RL8 - Trigger mode: restart also sets trigger
// RL9 - Load-ok set: swap lists on restart
// RL10 - Clear load-ok after restart swapped lists
// RL11 - Double-buffer mode off forces load-ok zero
// RL12 - Software sets load-ok with restart together
// RL13 - Writing one never clears set load-ok
// RL14 - Internal load-ready sampled when restart asserts
// RL15 - Restart mode: restart without load-ok errors
// RL16 - No load-ok error on first restart
// RL17 - Restart mode: restart plus trigger errors
// RL18 - Load-ok or trigger+abort need restart set
// RL19 - Clear trigger when first sampling starts
// RL20 - Disable or soft reset clears all
// RL21 - Unselected access source is ignored

package arls_pkg;

  // Register map
  localparam logic [7:0] FLOW_CTRL_OFFSET = 8'h05;
  localparam logic [7:0] FLOW_CTRL_RESET  = 8'h00;

  // Field positions inside conversion_flow_control
  localparam int ABORT_BIT   = 7;
  localparam int TRIGGER_BIT = 6;
  localparam int RESTART_BIT = 5;
  localparam int LOAD_READY_INPUT_BIT  = 4;

  // Access source encodings
  localparam logic [1:0] ACC_NONE     = 2'h0;
  localparam logic [1:0] ACC_DATA_BUS = 2'h1;
  localparam logic [1:0] ACC_INTERNAL = 2'h2;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_FETCH
  } arls_state_t;

  typedef struct packed {
    arls_state_t st;
    logic        restartBit;
    logic        triggerBit;
    logic        abortBit;
    logic        loadOkBit;
    logic        prevRestartReq;
    logic        prevTriggerReq;
    logic        prevAbortReq;
    logic        prevEnable;
    logic        firstPending;
    logic        abortBeforeRestart;
    logic        swapPending;
    logic        fetchTopCmd;
    logic        swapLists;
    logic        loadOkErr;
    logic        triggerErr;
    logic        restartOverrun;
    logic        triggerOverrun;
    logic        abortOverrun;
    logic [7:0]  rdData;
  } arls_regs_t;

endpackage : arls_pkg

//--- src/arls_flow_ctrl.sv
// Restart event and command list swap control of the converter flow.
// Assumes converter status inputs and internal requests are on clk.
`timescale 1ns/100ps
`default_nettype none

module arls_flow_ctrl (
  input  wire logic       clk,
  input  wire logic       resetn,
  // Data bus register port
  input  wire logic       busWrEn,
  input  wire logic       busRdEn,
  input  wire logic [7:0] busAddr,
  input  wire logic [7:0] busWrData,
  output logic      [7:0] busRdData,
  // Configuration
  input  wire logic       converterEnable,
  input  wire logic       softReset,
  input  wire logic       stopExit,
  input  wire logic [1:0] access_source_select,
  input  wire logic       list_double_buffer_mode,
  input  wire logic       triggerMode,
  // Internal request interface
  input  wire logic       restartReq,
  input  wire logic       load_ready_input,
  input  wire logic       triggerReq,
  input  wire logic       abortReq,
  // Converter status
  input  wire logic       convIdle,
  input  wire logic       endOfListSeen,
  input  wire logic       firstCmdLoaded,
  input  wire logic       sampleStart,
  input  wire logic       abortDone,
  // Flow outputs
  output logic            restart_event_bit,
  output logic            sequence_trigger_bit,
  output logic            sequence_abort_bit,
  output logic            list_load_ok_bit,
  output logic            fetchTopCmd,
  output logic            swapLists,
  output logic            load_ok_error_flag,
  output logic            trigger_error_flag,
  output logic            restartOverrun,
  output logic            triggerOverrun,
  output logic            abortOverrun
);

  arls_pkg::arls_regs_t s_reg;
  arls_pkg::arls_regs_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  logic busSel;
  logic intSel;
  logic flowWr;
  logic wrRestart;
  logic wrLoadOk;
  logic wrTrigger;
  logic wrAbort;
  logic restartRise;
  logic triggerRise;
  logic abortRise;
  logic reqRestart;
  logic reqLoadOk;
  logic reqTrigger;
  logic reqAbort;
  logic enableRise;
  logic clearAll;

  always_comb begin
    // RL6 source selection
    busSel = (access_source_select == arls_pkg::ACC_DATA_BUS);
    intSel = (access_source_select == arls_pkg::ACC_INTERNAL);
    flowWr = busWrEn && (busAddr == arls_pkg::FLOW_CTRL_OFFSET);
    // RL4 zeros ignored
    wrRestart = flowWr && busWrData[arls_pkg::RESTART_BIT];
    wrTrigger = flowWr && busWrData[arls_pkg::TRIGGER_BIT];
    wrAbort   = flowWr && busWrData[arls_pkg::ABORT_BIT];
    // RL12 paired write
    wrLoadOk  = wrRestart && busWrData[arls_pkg::LOAD_READY_INPUT_BIT];
    restartRise = restartReq && !s_reg.prevRestartReq;
    triggerRise = triggerReq && !s_reg.prevTriggerReq;
    abortRise   = abortReq && !s_reg.prevAbortReq;
    // RL21 other source ignored
    reqRestart = (busSel && wrRestart) || (intSel && restartRise);
    reqTrigger = (busSel && wrTrigger) || (intSel && triggerRise);
    reqAbort   = (busSel && wrAbort) || (intSel && abortRise);
    // RL14 load-ready sampled
    reqLoadOk  = (busSel && wrLoadOk) ||
                 (intSel && restartRise && load_ready_input);
    enableRise = converterEnable && !s_reg.prevEnable;
    // RL20 disable or soft reset
    clearAll   = !converterEnable || softReset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic restartSetNow;
  logic abortNow;

  always_comb begin
    s_next = s_reg;
    restartSetNow = 1'b0;
    abortNow = 1'b0;
    s_next.fetchTopCmd    = 1'b0;
    s_next.swapLists      = 1'b0;
    s_next.loadOkErr      = 1'b0;
    s_next.triggerErr     = 1'b0;
    s_next.restartOverrun = 1'b0;
    s_next.triggerOverrun = 1'b0;
    s_next.abortOverrun   = 1'b0;
    s_next.prevRestartReq = restartReq;
    s_next.prevTriggerReq = triggerReq;
    s_next.prevAbortReq   = abortReq;
    s_next.prevEnable     = converterEnable;
    s_next.rdData = 8'h00;
    if (busRdEn && busAddr == arls_pkg::FLOW_CTRL_OFFSET) begin
      s_next.rdData[arls_pkg::ABORT_BIT]   = s_reg.abortBit;
      s_next.rdData[arls_pkg::TRIGGER_BIT] = s_reg.triggerBit;
      s_next.rdData[arls_pkg::RESTART_BIT] = s_reg.restartBit;
      s_next.rdData[arls_pkg::LOAD_READY_INPUT_BIT]  = s_reg.loadOkBit;
    end
    // RL16 first restart exempt
    if (enableRise || stopExit || softReset) begin
      s_next.firstPending = 1'b1;
    end

    // Abort bit: set on request, cleared once the abort completed
    abortNow = reqAbort || s_reg.abortBit;
    if (reqAbort) begin
      if (s_reg.abortBit) begin
        s_next.abortOverrun = 1'b1;
      end
      s_next.abortBit = 1'b1;
    end
    if (abortDone) begin
      s_next.abortBit = 1'b0;
    end

    // RL7 restart request
    if (reqRestart) begin
      if (s_reg.restartBit) begin
        // RL5 overrun, not cleared
        s_next.restartOverrun = 1'b1;
      end else begin
        restartSetNow = 1'b1;
        s_next.restartBit = 1'b1;
        // Remember an abort seen before or with this restart
        s_next.abortBeforeRestart = abortNow;
        // RL8 trigger mode coupling
        if (triggerMode && (endOfListSeen || abortNow)) begin
          s_next.triggerBit = 1'b1;
        end
      end
      // RL9 load-ok marks list ready; RL13 never cleared by write
      if (reqLoadOk) begin
        s_next.loadOkBit = 1'b1;
      end
    end

    // Trigger request; RL18 trigger with abort only alongside restart
    if (reqTrigger) begin
      if (s_reg.triggerBit) begin
        s_next.triggerOverrun = 1'b1;
      end else if (!abortNow || s_next.restartBit) begin
        s_next.triggerBit = 1'b1;
      end
    end

    // RL17 restart mode conflict
    if (!triggerMode && s_next.restartBit && s_next.triggerBit &&
        !(s_reg.restartBit && s_reg.triggerBit)) begin
      s_next.triggerErr = 1'b1;
    end

    // RL19 sampling clears trigger
    if (sampleStart) begin
      s_next.triggerBit = 1'b0;
    end

    unique case (s_reg.st)
      arls_pkg::ST_IDLE: begin
        // RL1 fetch from list top
        if (s_reg.restartBit && convIdle) begin
          s_next.st = arls_pkg::ST_FETCH;
          s_next.fetchTopCmd = 1'b1;
          s_next.firstPending = 1'b0;
          s_next.swapPending = s_reg.loadOkBit;
          // RL9 exchange lists
          s_next.swapLists = s_reg.loadOkBit;
          // RL15 missing load-ok error
          if (!triggerMode && !s_reg.loadOkBit &&
              !s_reg.abortBeforeRestart && !s_reg.firstPending) begin
            s_next.loadOkErr = 1'b1;
          end
        end
      end
      arls_pkg::ST_FETCH: begin
        // RL2 clear after load
        if (firstCmdLoaded) begin
          s_next.st = arls_pkg::ST_IDLE;
          s_next.restartBit = restartSetNow;
          s_next.abortBeforeRestart = 1'b0;
          // RL10 clear after swap; RL18 never left without restart
          if (s_reg.swapPending || !s_next.restartBit) begin
            s_next.loadOkBit = 1'b0;
          end
          s_next.swapPending = 1'b0;
        end
      end
    endcase

    // RL11 single buffer mode
    if (!list_double_buffer_mode) begin
      s_next.loadOkBit = 1'b0;
    end

    // RL3 held clear when disabled
    if (clearAll) begin
      s_next.st = arls_pkg::ST_IDLE;
      s_next.restartBit = 1'b0;
      s_next.triggerBit = 1'b0;
      s_next.abortBit = 1'b0;
      s_next.loadOkBit = 1'b0;
      s_next.swapPending = 1'b0;
      s_next.abortBeforeRestart = 1'b0;
      s_next.fetchTopCmd = 1'b0;
      s_next.swapLists = 1'b0;
      s_next.loadOkErr = 1'b0;
      s_next.triggerErr = 1'b0;
      s_next.restartOverrun = 1'b0;
      s_next.triggerOverrun = 1'b0;
      s_next.abortOverrun = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Reset leaves firstPending set so the first restart raises no load-ok error
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{st: arls_pkg::ST_IDLE, firstPending: 1'b1,
                 rdData: arls_pkg::FLOW_CTRL_RESET, default: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops

  assign busRdData            = s_reg.rdData;
  assign restart_event_bit    = s_reg.restartBit;
  assign sequence_trigger_bit = s_reg.triggerBit;
  assign sequence_abort_bit   = s_reg.abortBit;
  assign list_load_ok_bit     = s_reg.loadOkBit;
  assign fetchTopCmd          = s_reg.fetchTopCmd;
  assign swapLists            = s_reg.swapLists;
  assign load_ok_error_flag   = s_reg.loadOkErr;
  assign trigger_error_flag   = s_reg.triggerErr;
  assign restartOverrun       = s_reg.restartOverrun;
  assign triggerOverrun       = s_reg.triggerOverrun;
  assign abortOverrun         = s_reg.abortOverrun;

endmodule : arls_flow_ctrl

`default_nettype wire

//--- test/arls_flow_ctrl_asserts.sv
// Port-level checks on the restart and list swap block.
// Assumes one clock domain; bound onto every arls_flow_ctrl.
`timescale 1ns/100ps
`default_nettype none
module arls_flow_ctrl_asserts (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       busWrEn,
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic       converterEnable,
  input wire logic       softReset,
  input wire logic [1:0] access_source_select,
  input wire logic       list_double_buffer_mode,
  input wire logic       triggerMode,
  input wire logic       restartReq,
  input wire logic       convIdle,
  input wire logic       endOfListSeen,
  input wire logic       firstCmdLoaded,
  input wire logic       restart_event_bit,
  input wire logic       sequence_trigger_bit,
  input wire logic       list_load_ok_bit,
  input wire logic       fetchTopCmd,
  input wire logic       swapLists,
  input wire logic       load_ok_error_flag,
  input wire logic       trigger_error_flag,
  input wire logic       restartOverrun
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Accepted bus write; soft reset excluded since it wins
  wire logic hit = busWrEn && busAddr == arls_pkg::FLOW_CTRL_OFFSET
    && access_source_select == arls_pkg::ACC_DATA_BUS
    && converterEnable && !softReset;
  chk_off_clears: assert property (
    !converterEnable |=> !restart_event_bit && !list_load_ok_bit)
    else $error("flow bits set while disabled");
  chk_zero_keeps: assert property (
    hit && !busWrData[5] && restart_event_bit && !firstCmdLoaded
    |=> restart_event_bit) else $error("zero write cleared restart");
  chk_set_overrun: assert property (
    hit && busWrData[5] && restart_event_bit
    |=> restartOverrun && restart_event_bit)
    else $error("no overrun on repeated restart");
  chk_buf_off: assert property (
    !list_double_buffer_mode |=> !list_load_ok_bit)
    else $error("load-ok set with buffering off");
  chk_list_load_ok_bit_alone: assert property (
    list_load_ok_bit |-> restart_event_bit)
    else $error("load-ok without restart");
  chk_sequence_trigger_bit_couple: assert property (
    $rose(restart_event_bit) && $past(triggerMode && endOfListSeen)
    |-> sequence_trigger_bit) else $error("trigger not coupled");
  chk_fetch_cause: assert property (
    fetchTopCmd |-> $past(restart_event_bit && convIdle))
    else $error("fetch without idle restart");
  chk_restart_event_bit_clear: assert property (
    firstCmdLoaded && !busWrEn && !restartReq |=> !restart_event_bit)
    else $error("restart kept after command load");
  chk_swap_cause: assert property (
    swapLists |-> fetchTopCmd && $past(list_load_ok_bit))
    else $error("swap without load-ok");
  chk_list_load_ok_bit_err: assert property (
    load_ok_error_flag |-> fetchTopCmd && !$past(triggerMode))
    else $error("load-ok error outside restart fetch");
  chk_sequence_trigger_bit_err: assert property (
    trigger_error_flag |-> !triggerMode && (sequence_trigger_bit
    || $past(sequence_trigger_bit))) else $error("stray trigger error");
endmodule : arls_flow_ctrl_asserts
bind arls_flow_ctrl arls_flow_ctrl_asserts arls_flow_ctrl_asserts_inst (.*);
`default_nettype wire

//--- test/arls_req_model.sv
// On-chip request source that drives the internal interface.
// Assumes kick is changed by the bench on falling edges.
`timescale 1ns/100ps
`default_nettype none
module arls_req_model (
  input  wire logic       clk,
  input  wire logic [2:0] kick,
  input  wire logic       ready,
  output logic            restartReq,
  output logic            load_ready_input,
  output logic            triggerReq,
  output logic            abortReq
);
  logic [2:0] held = 3'h0;
  initial {abortReq, triggerReq, restartReq, load_ready_input} = 4'h0;
  // one rising edge per kick, load ready valid with restart
  always @(posedge clk) begin
    held <= kick;
    {abortReq, triggerReq, restartReq} <= kick | held;
    load_ready_input <= (kick[0] | held[0]) ? ready : ~ready;
  end
endmodule : arls_req_model
`default_nettype wire

//--- test/tb_arls_flow_ctrl.sv
// Self-checking bench for the restart and list swap block.
// Assumes the checker binds itself; inputs move on falling edges.
`timescale 1ns/100ps
`default_nettype none
module tb_arls_flow_ctrl;
  logic       clk = 1'b0, resetn = 1'b0, busWrEn = 1'b0, busRdEn = 1'b0;
  logic       converterEnable = 1'b1, softReset = 1'b0, stopExit = 1'b0;
  logic       list_double_buffer_mode = 1'b1, triggerMode = 1'b0;
  logic       convIdle = 1'b0, endOfListSeen = 1'b0, ready = 1'b0;
  logic       firstCmdLoaded = 1'b0, sampleStart = 1'b0, abortDone = 1'b0;
  logic [1:0] access_source_select = 2'h1;
  logic [2:0] kick = 3'h0;
  logic [7:0] busAddr = 8'h05, busWrData = 8'h00, busRdData, rd;
  logic       restartReq, load_ready_input, triggerReq, abortReq;
  logic       restart_event_bit, sequence_trigger_bit, sequence_abort_bit;
  logic       list_load_ok_bit, fetchTopCmd, swapLists, load_ok_error_flag;
  logic       trigger_error_flag, restartOverrun, triggerOverrun, abortOverrun;
  int         err_count = 0, comparisons = 0;
  wire logic [3:0] evt = {restartOverrun, restart_event_bit,
                          trigger_error_flag, fetchTopCmd};
  // Rows: write data, access select, buffer mode, expected read
  localparam logic [18:0] ROWS [8] = '{
    {8'h20, 2'h1, 1'h1, 8'h20}, {8'h30, 2'h1, 1'h1, 8'h30},
    {8'h10, 2'h1, 1'h1, 8'h00}, {8'h30, 2'h1, 1'h0, 8'h20},
    {8'h30, 2'h2, 1'h1, 8'h00}, {8'h30, 2'h0, 1'h1, 8'h00},
    {8'h30, 2'h3, 1'h1, 8'h00}, {8'h00, 2'h1, 1'h1, 8'h00}};
  arls_flow_ctrl arls_flow_ctrl_inst (.*);
  arls_req_model arls_req_model_inst (.*);
  always #4 clk = ~clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("Counts: %0d compared, %0d mismatched", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic bus_wr(input logic [7:0] d);
    tick(1);
    busWrEn = 1'b1;
    busWrData = d;
    tick(1);
    busWrEn = 1'b0;
  endtask : bus_wr
  task automatic bus_rd();
    tick(1);
    busRdEn = 1'b1;
    tick(1);
    busRdEn = 1'b0;
    rd = busRdData;
  endtask : bus_rd
  // Bounded wait; running out ends the run
  task automatic wait_evt(input int k);
    // Look before stepping: pulses stand for one cycle only
    for (int i = 0; i < 16; i++) begin
      if (evt[k] === 1'b1) return;
      tick(1);
    end
    check(8'h00, 8'h01);
    complete_run();
  endtask : wait_evt
  task automatic pulse_off();
    converterEnable = 1'b0;
    tick(1);
    check({6'h0, restart_event_bit, list_load_ok_bit}, 8'h00);
    converterEnable = 1'b1;
  endtask : pulse_off
  initial begin
    tick(3);
    resetn = 1'b1;
    bus_rd();
    check(rd, arls_pkg::FLOW_CTRL_RESET);
    foreach (ROWS[i]) begin
      access_source_select = ROWS[i][10:9];
      list_double_buffer_mode = ROWS[i][8];
      bus_wr(ROWS[i][18:11]);
      bus_rd();
      check(rd, ROWS[i][7:0]);
      pulse_off();
    end
    $display("Test done: table");
    access_source_select = 2'h1;
    list_double_buffer_mode = 1'b1;
    bus_wr(8'h30);
    bus_wr(8'h30);
    check({5'h0, restart_event_bit, list_load_ok_bit, restartOverrun},
          8'h07);
    bus_wr(8'h00);
    check({6'h0, restart_event_bit, list_load_ok_bit}, 8'h03);
    convIdle = 1'b1;
    wait_evt(0);
    check({6'h0, swapLists, load_ok_error_flag}, 8'h02);
    firstCmdLoaded = 1'b1;
    convIdle = 1'b0;
    tick(1);
    firstCmdLoaded = 1'b0;
    check({6'h0, restart_event_bit, list_load_ok_bit}, 8'h00);
    bus_wr(8'h20);
    convIdle = 1'b1;
    wait_evt(0);
    check({7'h0, load_ok_error_flag}, 8'h01);
    firstCmdLoaded = 1'b1;
    convIdle = 1'b0;
    tick(1);
    firstCmdLoaded = 1'b0;
    $display("Test done: restart and swap");
    bus_wr(8'h60);
    wait_evt(1);
    sampleStart = 1'b1;
    tick(1);
    sampleStart = 1'b0;
    check({7'h0, sequence_trigger_bit}, 8'h00);
    pulse_off();
    bus_wr(8'h40);
    bus_wr(8'h40);
    check({6'h0, triggerOverrun, sequence_trigger_bit}, 8'h03);
    sampleStart = 1'b1;
    tick(1);
    sampleStart = 1'b0;
    bus_wr(8'h80);
    bus_wr(8'h80);
    check({6'h0, abortOverrun, sequence_abort_bit}, 8'h03);
    bus_wr(8'h40);
    check({7'h0, sequence_trigger_bit}, 8'h00);
    abortDone = 1'b1;
    tick(1);
    abortDone = 1'b0;
    check({7'h0, sequence_abort_bit}, 8'h00);
    $display("Test done: trigger error");
    access_source_select = 2'h2;
    triggerMode = 1'b1;
    endOfListSeen = 1'b1;
    ready = 1'b1;
    kick = 3'h1;
    tick(1);
    kick = 3'h0;
    wait_evt(2);
    check({5'h0, restart_event_bit, sequence_trigger_bit, list_load_ok_bit},
          8'h07);
    tick(3);
    kick = 3'h1;
    tick(1);
    kick = 3'h0;
    wait_evt(3);
    softReset = 1'b1;
    tick(1);
    softReset = 1'b0;
    check({6'h0, restart_event_bit, list_load_ok_bit}, 8'h00);
    $display("Test done: internal interface");
    complete_run();
  end
endmodule : tb_arls_flow_ctrl
`default_nettype wire
